/* stall_detect_regs.svh */
// Register indices, field positions, reset values and divider counts of the stall detector.
`ifndef STALL_DETECT_REGS_SVH
`define STALL_DETECT_REGS_SVH
// Register indices; the byte address is four times the index.
`define SSD_IDX_HOME 6'h00
`define SSD_IDX_MDC 6'h01
`define SSD_IDX_CTL 6'h02
`define SSD_IDX_FLG 6'h03
`define SSD_IDX_CNT 6'h04
`define SSD_IDX_ACC 6'h05
// Home seek register fields.
`define SSD_HOME_STEP 1:0
`define SSD_HOME_INTEG 2
`define SSD_HOME_WMASK 8'h07
// Down-counter control fields.
`define SSD_MDC_UIE 7
`define SSD_MDC_MOD 6
`define SSD_MDC_RDL 5
`define SSD_MDC_PRE 4
`define SSD_MDC_FLD 3
`define SSD_MDC_EN 2
`define SSD_MDC_OIE 0
`define SSD_MDC_WMASK 8'hF5
// Stall detect control fields.
`define SSD_CTL_HSE 7
`define SSD_CTL_PWR 6
`define SSD_CTL_WSD 5
`define SSD_CTL_SMP 1:0
`define SSD_CTL_WMASK 8'hE3
// Flag fields.
`define SSD_FLG_UF 7
`define SSD_FLG_OV 0
// Reset and special values.
`define SSD_RST_REG8 8'h00
`define SSD_CNT_PRESET 16'hFFFF
`define SSD_CNT_ZERO 16'h0000
`define SSD_CNT_ONE 16'h0001
`define SSD_ACC_MAX 16'h7FFF
`define SSD_ACC_MIN 16'h8000
// Divider figures and the word transfer size.
`define SSD_PRE_DIV_LO 64
`define SSD_PRE_DIV_HI 512
`define SSD_SMP_DIV_BASE 8
`define SSD_HSIZE_WORD 3'h2
`endif

/* ssd_pkg.sv */
// Types shared by the stall detector core.
package ssd_pkg;
    typedef struct packed {
        logic drive;
        logic recirculate;
        logic [1:0] step;
    } ssd_coil_s;
    typedef logic [15:0] ssd_word_t;
endpackage

/* ssd_core.sv */
// Stall detector core: AHB-Lite registers, down-counter, accumulator and coil control.
// What this block does
// (R1) Home seek enable drives coils to step state.
// (R2) Control bit powers sigma-delta converter on/off.
// (R3) Wait shutdown freezes prescaler, powers down, recirculates.
// (R4) Factory test bit always reads zero.
// (R5) Sample rate is clock over 8 times two^field.
// (R6) New sample rate applies after integrate cleared.
// (R7) Underflow flag at zero, write one clears.
// (R8) Overflow flag on saturation, write one clears.
// (R9) Count read gives live or load value.
// (R10) Writing zero keeps counter zero, no flag.
// (R11) Plain mode write loads register and counter.
// (R12) Reload mode write updates load register only.
// (R13) Counter ticks at clock over 64 or 512.
// (R14) Count register is accessed as one word.
// (R15) Accumulator is read only signed value.
// (R16) Integrate clear holds accumulator zero, converter reset.
// (R17) Integrate set counts up/down per sample.
// (R18) Accumulator saturates at 7FFF and 8000.
// (R19) Accumulator is read as one word.
// (R20) Reload mode reloads counter at zero.
// (R21) Disabled counter is preset to FFFF.
// (R22) Force reload reads zero, one copies load.
// (R23) Prescaler change applies at next counter load.
// (R24) Enabled counter decrements once per tick.
`include "stall_detect_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ssd_core #(
    parameter int PRE_DIV_LO = `SSD_PRE_DIV_LO,
    parameter int PRE_DIV_HI = `SSD_PRE_DIV_HI
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Motor side.
    input wire logic wait_mode,
    input wire logic sd_sample,
    output ssd_pkg::ssd_coil_s coil,
    output logic converter_power_on,
    output logic converter_reset,
    // Interrupt requests.
    output logic underflow_irq,
    output logic overflow_irq
);
    import ssd_pkg::*;

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic wr_q;
    logic word_q;
    logic [5:0] idx_q;
    logic [31:0] hrdata_q;
    logic [7:0] home_q;
    logic [7:0] mdc_q;
    logic [7:0] ctl_q;
    logic uf_q;
    logic ov_q;
    ssd_word_t cnt_q;
    ssd_word_t load_q;
    ssd_word_t acc_q;
    logic bus_take;
    logic [31:0] rd_val;

    function automatic logic wr_hit(input logic w, input logic [5:0] a, input logic [5:0] r);
        wr_hit = w && (a == r);
    endfunction

    assign bus_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            word_q <= 1'b0;
            idx_q <= `SSD_IDX_HOME;
        end else begin
            wr_q <= bus_take && hwrite;
            word_q <= hsize == `SSD_HSIZE_WORD;
            idx_q <= haddr[7:2];
        end
    end

    // Read data is latched at the address phase, so the data phase has no wait state.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (haddr[7:2])
            `SSD_IDX_HOME: rd_val[7:0] = home_q;
            `SSD_IDX_MDC: rd_val[7:0] = mdc_q;
            `SSD_IDX_CTL: rd_val[7:0] = ctl_q; // R4
            `SSD_IDX_FLG: begin
                rd_val[`SSD_FLG_UF] = uf_q;
                rd_val[`SSD_FLG_OV] = ov_q;
            end
            `SSD_IDX_CNT: rd_val[15:0] = mdc_q[`SSD_MDC_RDL] ? load_q : cnt_q; // R9
            `SSD_IDX_ACC: rd_val[15:0] = acc_q; // R15 R19
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            hrdata_q <= 32'h0000_0000;
        end else if (bus_take && !hwrite) begin
            hrdata_q <= rd_val;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    logic wr_cnt;
    logic force_ld;

    // Only whole-word writes reach the counter; narrower writes are dropped.
    assign wr_cnt = wr_hit(wr_q, idx_q, `SSD_IDX_CNT) && word_q; // R14
    assign force_ld = wr_hit(wr_q, idx_q, `SSD_IDX_MDC) && hwdata[`SSD_MDC_FLD]; // R22

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            home_q <= `SSD_RST_REG8;
            mdc_q <= `SSD_RST_REG8;
            ctl_q <= `SSD_RST_REG8;
        end else begin
            if (wr_hit(wr_q, idx_q, `SSD_IDX_HOME)) begin
                home_q <= hwdata[7:0] & `SSD_HOME_WMASK;
            end
            if (wr_hit(wr_q, idx_q, `SSD_IDX_MDC)) begin
                mdc_q <= hwdata[7:0] & `SSD_MDC_WMASK; // R22
            end
            if (wr_hit(wr_q, idx_q, `SSD_IDX_CTL)) begin
                ctl_q <= hwdata[7:0] & `SSD_CTL_WMASK; // R4
            end
        end
    end

    AST_CTL_TEST_ZERO: assert property (@(posedge core_clk) disable iff (!reset_n) // R4
        bus_take && !hwrite && haddr[7:2] == `SSD_IDX_CTL |=> !hrdata[4])
        else $error("factory test bit read back as one");

    // ************************************************************
    // Coil and converter control
    // ************************************************************
    logic freeze;
    logic integrate_select;
    ssd_coil_s coil_q;
    logic pwr_q;
    logic crst_q;

    assign integrate_select = home_q[`SSD_HOME_INTEG];
    assign freeze = wait_mode && ctl_q[`SSD_CTL_WSD]; // R3

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            coil_q <= '0;
            pwr_q <= 1'b0;
            crst_q <= 1'b1;
        end else begin
            coil_q.drive <= ctl_q[`SSD_CTL_HSE] && !freeze; // R1
            coil_q.recirculate <= ctl_q[`SSD_CTL_HSE] && freeze; // R3
            coil_q.step <= home_q[`SSD_HOME_STEP]; // R1
            pwr_q <= ctl_q[`SSD_CTL_PWR] && !freeze; // R2 R3
            crst_q <= !integrate_select; // R16
        end
    end

    assign coil = coil_q;
    assign converter_power_on = pwr_q;
    assign converter_reset = crst_q;

    AST_HOME_DRIVE: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
        ctl_q[`SSD_CTL_HSE] && !freeze |=> coil.drive && !coil.recirculate)
        else $error("coils not driven while home seek enabled");

    AST_WAIT_OFF: assert property (@(posedge core_clk) disable iff (!reset_n) // R3
        freeze ##1 freeze |-> !converter_power_on)
        else $error("converter powered during wait shutdown");

    // ************************************************************
    // Down-counter
    // ************************************************************
    logic [8:0] pre_cnt_q;
    logic pre_act_q;
    logic mc_en;
    logic mc_tick;
    logic direct_ld;
    logic uf_set;

    assign mc_en = mdc_q[`SSD_MDC_EN];
    assign mc_tick = mc_en && !freeze
        && pre_cnt_q == (pre_act_q ? 9'(PRE_DIV_HI - 1) : 9'(PRE_DIV_LO - 1)); // R13
    assign direct_ld = (wr_cnt && !mdc_q[`SSD_MDC_MOD]) || force_ld;
    assign uf_set = mc_tick && cnt_q == `SSD_CNT_ONE && !direct_ld; // R7

    // The prescaler stops, rather than resets, while frozen in wait.
    always_ff @(posedge core_clk) begin
        if (!reset_n || !mc_en) begin
            pre_cnt_q <= 9'h000;
        end else if (mc_tick) begin
            pre_cnt_q <= 9'h000;
        end else if (!freeze) begin
            pre_cnt_q <= pre_cnt_q + 9'h001; // R13 R3
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            load_q <= `SSD_CNT_PRESET;
        end else if (wr_cnt) begin
            load_q <= hwdata[15:0]; // R11 R12
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cnt_q <= `SSD_CNT_PRESET;
            pre_act_q <= 1'b0;
        end else if (!mc_en) begin
            cnt_q <= `SSD_CNT_PRESET; // R21 R24
            pre_act_q <= mdc_q[`SSD_MDC_PRE]; // R23
        end else if (wr_cnt && !mdc_q[`SSD_MDC_MOD]) begin
            cnt_q <= hwdata[15:0]; // R11 R10
            pre_act_q <= mdc_q[`SSD_MDC_PRE]; // R23
        end else if (force_ld) begin
            cnt_q <= load_q; // R22 R12
            pre_act_q <= mdc_q[`SSD_MDC_PRE]; // R23
        end else if (mc_tick && cnt_q != `SSD_CNT_ZERO) begin
            if (cnt_q == `SSD_CNT_ONE && mdc_q[`SSD_MDC_MOD]) begin
                cnt_q <= load_q; // R20
                pre_act_q <= mdc_q[`SSD_MDC_PRE]; // R23
            end else begin
                cnt_q <= cnt_q - `SSD_CNT_ONE; // R24 R11
            end
        end
    end

    AST_PRESET: assert property (@(posedge core_clk) disable iff (!reset_n) // R21
        !mc_en |=> cnt_q == `SSD_CNT_PRESET)
        else $error("disabled counter not preset");

    AST_FORCE_LOAD: assert property (@(posedge core_clk) disable iff (!reset_n) // R22
        mc_en && force_ld |=> cnt_q == $past(load_q))
        else $error("force reload did not copy load value");

    AST_ZERO_STAYS: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
        mc_en && cnt_q == `SSD_CNT_ZERO && !direct_ld |=> cnt_q == `SSD_CNT_ZERO && !uf_set)
        else $error("counter left zero without a load");

    AST_RELOAD: assert property (@(posedge core_clk) disable iff (!reset_n) // R20
        uf_set && mdc_q[`SSD_MDC_MOD] |=> cnt_q == $past(load_q) && uf_q)
        else $error("reload mode did not reload at underflow");

    // ************************************************************
    // Accumulator
    // ************************************************************
    logic [5:0] smp_cnt_q;
    logic [1:0] smp_sel_q;
    logic smp_tick;
    logic ov_set;

    assign smp_tick = integrate_select && !freeze
        && smp_cnt_q == 6'((`SSD_SMP_DIV_BASE << smp_sel_q) - 1); // R5 R17
    assign ov_set = smp_tick && ((sd_sample && acc_q == `SSD_ACC_MAX)
        || (!sd_sample && acc_q == `SSD_ACC_MIN)); // R8

    // The rate is sampled only while idle, so a running integration keeps one rate.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            smp_sel_q <= 2'h0;
        end else if (!integrate_select) begin
            smp_sel_q <= ctl_q[`SSD_CTL_SMP]; // R6
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || !integrate_select || smp_tick) begin
            smp_cnt_q <= 6'h00;
        end else if (!freeze) begin
            smp_cnt_q <= smp_cnt_q + 6'h01; // R5
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n || !integrate_select) begin
            acc_q <= `SSD_CNT_ZERO; // R16
        end else if (smp_tick && !ov_set) begin
            acc_q <= sd_sample ? acc_q + `SSD_CNT_ONE : acc_q - `SSD_CNT_ONE; // R17 R18
        end
    end

    AST_ACC_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n) // R16
        !integrate_select |=> acc_q == `SSD_CNT_ZERO && converter_reset)
        else $error("accumulator not cleared while integrate off");

    AST_ACC_SAT: assert property (@(posedge core_clk) disable iff (!reset_n) // R18
        smp_tick && sd_sample && acc_q == `SSD_ACC_MAX |=> acc_q == `SSD_ACC_MAX && ov_q)
        else $error("accumulator wrapped past positive limit");

    AST_RATE_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n) // R6
        integrate_select && $past(integrate_select) |-> $stable(smp_sel_q))
        else $error("sample rate changed during integration");

    // ************************************************************
    // Flags
    // ************************************************************
    logic wr_flg;

    assign wr_flg = wr_hit(wr_q, idx_q, `SSD_IDX_FLG);

    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            uf_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            uf_q <= uf_set || (uf_q && !(wr_flg && hwdata[`SSD_FLG_UF])); // R7
            ov_q <= ov_set || (ov_q && !(wr_flg && hwdata[`SSD_FLG_OV])); // R8
        end
    end

    assign underflow_irq = uf_q && mdc_q[`SSD_MDC_UIE]; // R7
    assign overflow_irq = ov_q && mdc_q[`SSD_MDC_OIE]; // R8

    AST_UF_SET: assert property (@(posedge core_clk) disable iff (!reset_n) // R7
        uf_set |=> uf_q)
        else $error("underflow flag not set");

    AST_OV_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
        ov_q && wr_flg && hwdata[`SSD_FLG_OV] && !ov_set |=> !ov_q)
        else $error("overflow flag not cleared by write one");

endmodule

`default_nettype wire

/* ssd_conv_model.sv */
// Behavioural sigma-delta converter on the motor side of the stall detector.
`timescale 1ns/1ps
`default_nettype none
module ssd_conv_model (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Converter control.
    input wire logic power_on,
    input wire logic conv_reset,
    // Converter output.
    output logic sd_sample
);
    // ************************************************
    // Output bit
    // ************************************************
    logic flip_q = 1'b0;
    // An unpowered or reset converter gives no valid bit, so the line wanders every cycle.
    always_ff @(posedge core_clk) begin
        flip_q <= ~flip_q;
        if (!reset_n || !power_on || conv_reset) begin
            sd_sample <= flip_q;
        end else begin
            sd_sample <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* ssd_tb.sv */
// Self-checking bench for the stall detector core.
`include "stall_detect_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssd_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic wait_mode = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = `SSD_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] v;
    logic [31:0] a;
    logic hreadyout;
    logic hresp;
    logic sd_sample;
    logic pwr;
    logic crst;
    logic uirq;
    logic oirq;
    ssd_coil_s coil;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // ************************************************
    // Clock, design and converter
    // ************************************************
    always #20 core_clk = ~core_clk;
    // Short dividers keep the counter runs brief; expectations use 4 and 8.
    ssd_core #(.PRE_DIV_LO(4), .PRE_DIV_HI(8)) ssd_core_inst (.core_clk(core_clk),
        .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .wait_mode(wait_mode), .sd_sample(sd_sample),
        .coil(coil), .converter_power_on(pwr), .converter_reset(crst),
        .underflow_irq(uirq), .overflow_irq(oirq));
    ssd_conv_model ssd_conv_model_inst (.core_clk(core_clk), .reset_n(reset_n),
        .power_on(pwr), .conv_reset(crst), .sd_sample(sd_sample));
    // ************************************************
    // Bus tasks and checks
    // ************************************************
    task automatic xfer(input logic w, input logic [5:0] i, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {i, 2'h0};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task automatic rc(input string n, input logic [5:0] i, input logic [31:0] e);
        xfer(1'b0, i, 32'h0000_0000);
        chk(n, e, v);
    endtask
    // Two reads 64 cycles apart, so the step is exact whatever the sample phase.
    task automatic meas(input logic [31:0] e);
        xfer(1'b0, `SSD_IDX_ACC, 32'h0000_0000);
        a = v;
        repeat (62) @(posedge core_clk);
        rc("acc_step", `SSD_IDX_ACC, a + e);
    endtask
    task automatic outs(input logic [3:0] c, input logic p);
        repeat (3) @(posedge core_clk);
        chk("coil", {28'h0, c}, {28'h0, coil});
        chk("power", 32'h1, {31'h0, pwr === p});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rc("ctl_rst", `SSD_IDX_CTL, 32'h0000_0000);
        rc("cnt_rst", `SSD_IDX_CNT, 32'h0000_FFFF);
        rc("acc_rst", `SSD_IDX_ACC, 32'h0000_0000);
        xfer(1'b1, 6'h06, 32'h0000_00FF);
        rc("unmapped", 6'h06, 32'h0000_0000);
        $display("reset test done");
        xfer(1'b1, `SSD_IDX_CTL, 32'h0000_00FF);
        rc("ctl_rd", `SSD_IDX_CTL, 32'h0000_00E3);
        xfer(1'b1, `SSD_IDX_HOME, 32'h0000_0003);
        outs(4'b1011, 1'b1);
        wait_mode <= 1'b1;
        outs(4'b0111, 1'b0);
        xfer(1'b1, `SSD_IDX_CTL, 32'h0000_00C0);
        outs(4'b1011, 1'b1);
        wait_mode <= 1'b0;
        xfer(1'b1, `SSD_IDX_CTL, 32'h0000_0000);
        outs(4'b0011, 1'b0);
        $display("control test done");
        xfer(1'b1, `SSD_IDX_CTL, 32'h0000_0040);
        xfer(1'b1, `SSD_IDX_HOME, 32'h0000_0004);
        meas(32'h0000_0008);
        xfer(1'b1, `SSD_IDX_ACC, 32'h0000_1234);
        xfer(1'b0, `SSD_IDX_ACC, 32'h0000_0000);
        chk("acc_ro", 32'h1, {31'h0, v < 32'h0000_0100});
        xfer(1'b1, `SSD_IDX_CTL, 32'h0000_0043);
        meas(32'h0000_0008);
        xfer(1'b1, `SSD_IDX_HOME, 32'h0000_0000);
        // The clear lands one cycle after the register write, so let it settle first.
        @(posedge core_clk);
        rc("acc_clr", `SSD_IDX_ACC, 32'h0000_0000);
        chk("conv_rst", 32'h1, {31'h0, crst});
        xfer(1'b1, `SSD_IDX_HOME, 32'h0000_0004);
        meas(32'h0000_0001);
        xfer(1'b1, `SSD_IDX_HOME, 32'h0000_0000);
        $display("accumulator test done");
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0084);
        xfer(1'b1, `SSD_IDX_CNT, 32'h0000_0003);
        repeat (40) @(posedge core_clk);
        rc("cnt_halt", `SSD_IDX_CNT, 32'h0000_0000);
        rc("uf_set", `SSD_IDX_FLG, 32'h0000_0080);
        chk("uf_irq", 32'h1, {31'h0, uirq});
        xfer(1'b1, `SSD_IDX_FLG, 32'h0000_0000);
        rc("uf_w0", `SSD_IDX_FLG, 32'h0000_0080);
        xfer(1'b1, `SSD_IDX_FLG, 32'h0000_0080);
        rc("uf_w1", `SSD_IDX_FLG, 32'h0000_0000);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0000);
        @(posedge core_clk);
        rc("preset", `SSD_IDX_CNT, 32'h0000_FFFF);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0014);
        xfer(1'b1, `SSD_IDX_CNT, 32'h0000_0003);
        repeat (14) @(posedge core_clk);
        rc("slow_pre", `SSD_IDX_FLG, 32'h0000_0000);
        repeat (20) @(posedge core_clk);
        rc("slow_uf", `SSD_IDX_FLG, 32'h0000_0080);
        xfer(1'b1, `SSD_IDX_FLG, 32'h0000_0080);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0004);
        xfer(1'b1, `SSD_IDX_CNT, 32'h0000_0000);
        repeat (20) @(posedge core_clk);
        rc("zero_cnt", `SSD_IDX_CNT, 32'h0000_0000);
        rc("zero_flg", `SSD_IDX_FLG, 32'h0000_0000);
        hsize <= 3'h0;
        xfer(1'b1, `SSD_IDX_CNT, 32'h0000_0007);
        hsize <= `SSD_HSIZE_WORD;
        rc("narrow", `SSD_IDX_CNT, 32'h0000_0000);
        chk("ov_irq", 32'h0, {31'h0, oirq});
        chk("hresp", 32'h0, {31'h0, hresp});
        $display("counter test done");
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0000);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0044);
        xfer(1'b1, `SSD_IDX_CNT, 32'h0000_0005);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0064);
        rc("load_rd", `SSD_IDX_CNT, 32'h0000_0005);
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0044);
        xfer(1'b0, `SSD_IDX_CNT, 32'h0000_0000);
        chk("cnt_keep", 32'h1, {31'h0, v > 32'h0000_FF00});
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_004C);
        rc("fld_zero", `SSD_IDX_MDC, 32'h0000_0044);
        xfer(1'b0, `SSD_IDX_CNT, 32'h0000_0000);
        chk("forced", 32'h1, {31'h0, v <= 32'h0000_0005 && v >= 32'h0000_0004});
        repeat (40) @(posedge core_clk);
        rc("rl_flag", `SSD_IDX_FLG, 32'h0000_0080);
        xfer(1'b0, `SSD_IDX_CNT, 32'h0000_0000);
        chk("reload", 32'h1, {31'h0, v <= 32'h0000_0005 && v >= 32'h0000_0001});
        xfer(1'b1, `SSD_IDX_MDC, 32'h0000_0000);
        @(posedge core_clk);
        rc("stop", `SSD_IDX_CNT, 32'h0000_FFFF);
        $display("reload test done");
        test_done();
    end
endmodule
`default_nettype wire
